/* File: hw/rsr_pkg.sv */
// constants for the ramp status register bank
// How it works
// RULE1 - bit 15 shows right virtual stop
// RULE2 - bit 14 shows left virtual stop
// RULE3 - bit 13 mirrors the stall input
// RULE4 - bit 12 sticky on ramp reversal, W1C
// RULE5 - bit 11 high during standstill wait
// RULE6 - bit 10 high at zero velocity
// RULE7 - bit 9 high while position matches target
// RULE8 - reset: bits 15,14 one, rest zero
// RULE9 - software should enable stop on stall
// RULE10 - bit 8 high at maximum velocity
// RULE11 - bit 7 sticky on position match, W1C
// RULE12 - bits 5,4 show active stop conditions
// RULE13 - bits 3,2 sticky latch events, W1C
// RULE14 - W1C zero keeps; read-only ignored; set wins
// RULE15 - bits 1,0 show polarised, swapped switches
package rsr_pkg;
   localparam int RSR_ADDR_W = 8;
   localparam int RSR_DATA_W = 32;
   // status word sits at a word index, not a byte address
   localparam logic [7:0] RSR_STATUS_IDX = 8'h35;
   localparam logic [7:0] RSR_STATUS_ADDR = {RSR_STATUS_IDX[5:0], 2'b00};
   localparam logic [7:0] RSR_SWMODE_ADDR = 8'h00;
   localparam logic [7:0] RSR_WAIT_ADDR = 8'h04;
   localparam logic [7:0] RSR_INT_STAT_ADDR = 8'h08;
   localparam logic [7:0] RSR_INT_MASK_ADDR = 8'h0c;
   // status bit positions
   localparam int RSR_B_VSTOP_R = 15;
   localparam int RSR_B_VSTOP_L = 14;
   localparam int RSR_B_STALL = 13;
   localparam int RSR_B_REVERSE = 12;
   localparam int RSR_B_WAIT = 11;
   localparam int RSR_B_VEL_ZERO = 10;
   localparam int RSR_B_POS_MATCH = 9;
   localparam int RSR_B_VEL_MAX = 8;
   localparam int RSR_B_POS_EVT = 7;
   localparam int RSR_B_STALL_EVT = 6;
   localparam int RSR_B_STOP_R = 5;
   localparam int RSR_B_STOP_L = 4;
   localparam int RSR_B_LATCH_R = 3;
   localparam int RSR_B_LATCH_L = 2;
   localparam int RSR_B_REF_R = 1;
   localparam int RSR_B_REF_L = 0;
   localparam logic [31:0] RSR_STATUS_RST = 32'h0000c000;
   localparam logic [31:0] RSR_EVT_LAYOUT = 32'h000010fc;
   // switch-mode field positions
   localparam int RSR_SW_STOP_L_EN = 0;
   localparam int RSR_SW_STOP_R_EN = 1;
   localparam int RSR_SW_POL_L = 2;
   localparam int RSR_SW_POL_R = 3;
   localparam int RSR_SW_SWAP = 4;
   localparam int RSR_SW_LATCH_L_ACT = 5;
   localparam int RSR_SW_LATCH_L_INACT = 6;
   localparam int RSR_SW_LATCH_R_ACT = 7;
   localparam int RSR_SW_LATCH_R_INACT = 8;
   localparam int RSR_SW_STALL_STOP = 10;
   localparam int RSR_SW_VSTOP_L_EN = 12;
   localparam int RSR_SW_VSTOP_R_EN = 13;
   localparam logic [13:0] RSR_SWMODE_RST = 14'h0000;
   localparam logic [15:0] RSR_WAIT_RST = 16'h0000;
   localparam logic [31:0] RSR_INT_MASK_RST = 32'h00000000;
   localparam int RSR_WAIT_TICK_CYCLES = 512;
   localparam logic [1:0] RSR_RESP_OKAY = 2'b00;
   localparam logic [1:0] RSR_RESP_SLVERR = 2'b10;
endpackage : rsr_pkg

/* File: hw/rsr_axil.sv */
// axi4-lite slave front end for the ramp status bank
module rsr_axil import rsr_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [RSR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [RSR_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [RSR_ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic rd_en,
   output logic [RSR_ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_got_r, w_got_r, ar_got_r;
   logic awready_r, wready_r, arready_r, bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;

   assign wr_en = aw_got_r && w_got_r && !bvalid_r;
   assign rd_en = ar_got_r && !rvalid_r;

   // address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         aw_got_r <= 1'b0;
         wr_addr <= '0;
      end else if (s_axi_awvalid && awready_r) begin
         awready_r <= 1'b0;
         aw_got_r <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end else if (wr_en) begin
         aw_got_r <= 1'b0;
      end else if (!aw_got_r && !bvalid_r) begin
         awready_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_r <= 1'b0;
         w_got_r <= 1'b0;
         wr_data <= '0;
         wr_strb <= '0;
      end else if (s_axi_wvalid && wready_r) begin
         wready_r <= 1'b0;
         w_got_r <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (wr_en) begin
         w_got_r <= 1'b0;
      end else if (!w_got_r && !bvalid_r) begin
         wready_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RSR_RESP_OKAY;
      end else if (wr_en) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_err ? RSR_RESP_SLVERR : RSR_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         ar_got_r <= 1'b0;
         rd_addr <= '0;
      end else if (s_axi_arvalid && arready_r) begin
         arready_r <= 1'b0;
         ar_got_r <= 1'b1;
         rd_addr <= s_axi_araddr;
      end else if (rd_en) begin
         ar_got_r <= 1'b0;
      end else if (!ar_got_r && !rvalid_r) begin
         arready_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RSR_RESP_OKAY;
      end else if (rd_en) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_data;
         rresp_r <= rd_err ? RSR_RESP_SLVERR : RSR_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   a_bresp_stable: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before ready");
   a_rdata_stable: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before ready");
endmodule : rsr_axil

/* File: hw/rsr_top.sv */
// ramp status register bank with axi4-lite access and interrupt
module rsr_top import rsr_pkg::*; #(
   parameter int WAIT_TICK_CYCLES = RSR_WAIT_TICK_CYCLES,
   parameter int POS_W = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [RSR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [RSR_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ref_l_pin,
   input wire logic ref_r_pin,
   input wire logic virt_stop_l_cond,
   input wire logic virt_stop_r_cond,
   input wire logic stall_in,
   input wire logic ramp_reversal,
   input wire logic motor_stopped,
   input wire logic hold_mode,
   input wire logic move_negative,
   input wire logic [POS_W-1:0] actual_position,
   input wire logic [POS_W-1:0] target_position,
   input wire logic [POS_W-1:0] actual_velocity,
   input wire logic [POS_W-1:0] max_velocity,
   output logic stop_on_stall_enable,
   output logic irq
);
   logic wr_en, rd_en, wr_err, rd_err;
   logic [RSR_ADDR_W-1:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;

   rsr_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // sticky flag: a set in the clearing cycle survives
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set || (cur && !clr);
   endfunction : sticky

   function automatic logic is_mapped(input logic [RSR_ADDR_W-1:0] a);
      is_mapped = (a == RSR_STATUS_ADDR) || (a == RSR_SWMODE_ADDR) || (a == RSR_WAIT_ADDR)
         || (a == RSR_INT_STAT_ADDR) || (a == RSR_INT_MASK_ADDR);
   endfunction : is_mapped

   // configuration registers
   logic [13:0] swmode_r;
   logic [15:0] wait_time_r;
   logic [31:0] int_mask_r;
   logic [31:0] int_stat_r;
   logic [31:0] status_r;
   logic [31:0] wmask;

   assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign wr_err = !is_mapped(wr_addr);
   assign rd_err = !is_mapped(rd_addr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         swmode_r <= RSR_SWMODE_RST;
      end else if (wr_en && wr_addr == RSR_SWMODE_ADDR) begin
         swmode_r <= (swmode_r & ~wmask[13:0]) | (wr_data[13:0] & wmask[13:0]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_time_r <= RSR_WAIT_RST;
      end else if (wr_en && wr_addr == RSR_WAIT_ADDR) begin
         wait_time_r <= (wait_time_r & ~wmask[15:0]) | (wr_data[15:0] & wmask[15:0]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_mask_r <= RSR_INT_MASK_RST;
      end else if (wr_en && wr_addr == RSR_INT_MASK_ADDR) begin
         int_mask_r <= ((int_mask_r & ~wmask) | (wr_data & wmask)) & RSR_EVT_LAYOUT;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_on_stall_enable <= 1'b0;
      end else begin
         stop_on_stall_enable <= swmode_r[RSR_SW_STALL_STOP];
      end
   end

   // reference switch conditioning
   logic sw_l_act, sw_r_act;
   logic sw_l_q, sw_r_q;
   assign sw_l_act = (swmode_r[RSR_SW_SWAP] ? ref_r_pin : ref_l_pin) ^ swmode_r[RSR_SW_POL_L]; // RULE15
   assign sw_r_act = (swmode_r[RSR_SW_SWAP] ? ref_l_pin : ref_r_pin) ^ swmode_r[RSR_SW_POL_R]; // RULE15

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_l_q <= 1'b0;
         sw_r_q <= 1'b0;
      end else begin
         sw_l_q <= sw_l_act;
         sw_r_q <= sw_r_act;
      end
   end

   logic latch_l_set, latch_r_set;
   assign latch_l_set = (swmode_r[RSR_SW_LATCH_L_ACT] && sw_l_act && !sw_l_q)
      || (swmode_r[RSR_SW_LATCH_L_INACT] && !sw_l_act && sw_l_q); // RULE13
   assign latch_r_set = (swmode_r[RSR_SW_LATCH_R_ACT] && sw_r_act && !sw_r_q)
      || (swmode_r[RSR_SW_LATCH_R_INACT] && !sw_r_act && sw_r_q); // RULE13

   // stop conditions are levels; hold mode, reverse move or disable drop them
   logic stop_l_now, stop_r_now;
   assign stop_l_now = ((sw_l_act && swmode_r[RSR_SW_STOP_L_EN])
      || (virt_stop_l_cond && swmode_r[RSR_SW_VSTOP_L_EN])) && !hold_mode && move_negative; // RULE12
   assign stop_r_now = ((sw_r_act && swmode_r[RSR_SW_STOP_R_EN])
      || (virt_stop_r_cond && swmode_r[RSR_SW_VSTOP_R_EN])) && !hold_mode && !move_negative; // RULE12

   // standstill wait timer, counted on a divided tick
   localparam int TICK_W = $clog2(WAIT_TICK_CYCLES + 1);
   logic [TICK_W-1:0] tick_cnt_r;
   logic tick;
   logic [15:0] wait_cnt_r;
   logic wait_active_r;
   assign tick = tick_cnt_r == TICK_W'(WAIT_TICK_CYCLES - 1);

   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
      end
   end

   // a new stop restarts the interval rather than extending it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_cnt_r <= RSR_WAIT_RST;
         wait_active_r <= 1'b0;
      end else if (motor_stopped) begin
         wait_cnt_r <= wait_time_r; // RULE5
         wait_active_r <= wait_time_r != 16'h0000; // RULE5
      end else if (wait_active_r && tick) begin
         wait_cnt_r <= wait_cnt_r - 1'b1;
         if (wait_cnt_r == 16'h0001) begin
            wait_active_r <= 1'b0; // RULE5
         end
      end
   end

   // status word
   logic pos_match, stat_clr;
   logic [31:0] stat_nxt;
   assign pos_match = actual_position == target_position;
   assign stat_clr = wr_en && wr_addr == RSR_STATUS_ADDR;

   always_comb begin
      stat_nxt = '0; // RULE8
      stat_nxt[RSR_B_VSTOP_R] = virt_stop_r_cond; // RULE1
      stat_nxt[RSR_B_VSTOP_L] = virt_stop_l_cond; // RULE2
      stat_nxt[RSR_B_STALL] = stall_in; // RULE3
      stat_nxt[RSR_B_REVERSE] = sticky(status_r[RSR_B_REVERSE], ramp_reversal,
         stat_clr && wr_strb[1] && wr_data[RSR_B_REVERSE]); // RULE4 RULE14
      stat_nxt[RSR_B_WAIT] = wait_active_r; // RULE5
      stat_nxt[RSR_B_VEL_ZERO] = actual_velocity == '0; // RULE6
      stat_nxt[RSR_B_POS_MATCH] = pos_match; // RULE7
      stat_nxt[RSR_B_VEL_MAX] = actual_velocity == max_velocity; // RULE10
      stat_nxt[RSR_B_POS_EVT] = sticky(status_r[RSR_B_POS_EVT],
         pos_match && !status_r[RSR_B_POS_MATCH],
         stat_clr && wr_strb[0] && wr_data[RSR_B_POS_EVT]); // RULE11 RULE14
      stat_nxt[RSR_B_STALL_EVT] = sticky(status_r[RSR_B_STALL_EVT],
         stall_in && swmode_r[RSR_SW_STALL_STOP],
         stat_clr && wr_strb[0] && wr_data[RSR_B_STALL_EVT]); // RULE14
      stat_nxt[RSR_B_STOP_R] = stop_r_now; // RULE12
      stat_nxt[RSR_B_STOP_L] = stop_l_now; // RULE12
      stat_nxt[RSR_B_LATCH_R] = sticky(status_r[RSR_B_LATCH_R], latch_r_set,
         stat_clr && wr_strb[0] && wr_data[RSR_B_LATCH_R]); // RULE13 RULE14
      stat_nxt[RSR_B_LATCH_L] = sticky(status_r[RSR_B_LATCH_L], latch_l_set,
         stat_clr && wr_strb[0] && wr_data[RSR_B_LATCH_L]); // RULE13 RULE14
      stat_nxt[RSR_B_REF_R] = sw_r_act; // RULE15
      stat_nxt[RSR_B_REF_L] = sw_l_act; // RULE15
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= RSR_STATUS_RST; // RULE8
      end else begin
         status_r <= stat_nxt;
      end
   end

   // interrupt status: rising event bits, cleared by reading it
   logic [31:0] evt_rise;
   logic int_rd_clr;
   assign evt_rise = stat_nxt & ~status_r & RSR_EVT_LAYOUT;
   assign int_rd_clr = rd_en && rd_addr == RSR_INT_STAT_ADDR;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_stat_r <= '0;
      end else begin
         int_stat_r <= evt_rise | (int_stat_r & ~{32{int_rd_clr}}); // RULE14
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat_r & int_mask_r);
      end
   end

   always_comb begin
      rd_data = '0;
      unique case (rd_addr)
         RSR_STATUS_ADDR: rd_data = status_r;
         RSR_SWMODE_ADDR: rd_data = {18'h00000, swmode_r};
         RSR_WAIT_ADDR: rd_data = {16'h0000, wait_time_r};
         RSR_INT_STAT_ADDR: rd_data = int_stat_r;
         RSR_INT_MASK_ADDR: rd_data = int_mask_r;
         default: rd_data = '0;
      endcase
   end

   a_vstop_right: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
      virt_stop_r_cond |=> status_r[RSR_B_VSTOP_R])
      else $error("right virtual stop not shown");

   a_vstop_left: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
      !virt_stop_l_cond |=> !status_r[RSR_B_VSTOP_L])
      else $error("left virtual stop shown while inactive");

   a_stall_mirror: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
      stall_in ##1 !stall_in |-> status_r[RSR_B_STALL] ##1 !status_r[RSR_B_STALL])
      else $error("stall flag does not follow input");

   a_reverse_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
      status_r[RSR_B_REVERSE] && !stat_clr |=> status_r[RSR_B_REVERSE])
      else $error("reversal flag lost without clear");

   a_wait_start: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
      motor_stopped && wait_time_r != 16'h0000 |=> ##1 status_r[RSR_B_WAIT])
      else $error("standstill wait not shown");

   a_vel_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
      actual_velocity == '0 |=> status_r[RSR_B_VEL_ZERO])
      else $error("zero velocity not shown");

   a_pos_match: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
      actual_position != target_position |=> !status_r[RSR_B_POS_MATCH])
      else $error("position match shown while unequal");

   a_reset_value: assert property (@(posedge aclk) // RULE8
      !aresetn |=> status_r == RSR_STATUS_RST)
      else $error("wrong status after reset");

   a_vel_max: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
      actual_velocity == max_velocity |=> status_r[RSR_B_VEL_MAX])
      else $error("maximum velocity not shown");

   a_pos_event: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
      $rose(status_r[RSR_B_POS_MATCH]) |-> status_r[RSR_B_POS_EVT])
      else $error("position event not set on match");

   a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
      hold_mode |=> !status_r[RSR_B_STOP_R] && !status_r[RSR_B_STOP_L])
      else $error("stop condition survives hold mode");

   a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
      stall_in && swmode_r[RSR_SW_STALL_STOP] |=> status_r[RSR_B_STALL_EVT])
      else $error("stall event lost");

   a_ref_state: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
      $stable(swmode_r) && $rose(sw_r_act) |=> status_r[RSR_B_REF_R])
      else $error("right switch state not shown");

   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      (int_stat_r & int_mask_r) == '0 |=> !irq)
      else $error("interrupt without unmasked event");

   a_stop_left_dir: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
      !move_negative |=> !status_r[RSR_B_STOP_L])
      else $error("left stop shown while moving right");

   a_vel_moving: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
      actual_velocity != '0 |=> !status_r[RSR_B_VEL_ZERO])
      else $error("zero velocity shown while moving");

   a_wait_idle: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
      !wait_active_r && !motor_stopped |=> ##1 !status_r[RSR_B_WAIT])
      else $error("standstill wait shown without stop");

   a_latch_keep: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
      status_r[RSR_B_LATCH_L] && !stat_clr |=> status_r[RSR_B_LATCH_L])
      else $error("left latch flag lost without clear");

   a_zero_keeps: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
      status_r[RSR_B_POS_EVT] && !wr_data[RSR_B_POS_EVT] |=> status_r[RSR_B_POS_EVT])
      else $error("position event lost on zero write");

   a_int_set_wins: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
      evt_rise[RSR_B_REVERSE] |=> int_stat_r[RSR_B_REVERSE])
      else $error("reversal interrupt lost");
endmodule : rsr_top

/* File: bench/test_ramp_status_register.sv */
// self-checking bench for the ramp status register bank
module test_ramp_status_register import rsr_pkg::*; ();
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic ref_l_pin, ref_r_pin, virt_stop_l_cond, virt_stop_r_cond, stall_in, ramp_reversal;
   logic motor_stopped, hold_mode, move_negative, stop_on_stall_enable, irq;
   logic [31:0] actual_position, target_position, actual_velocity, max_velocity;
   int err_total, checked, cyc;

   // short tick so the standstill wait fits in a few reads
   rsr_top #(.WAIT_TICK_CYCLES(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_l_pin, .ref_r_pin,
      .virt_stop_l_cond, .virt_stop_r_cond, .stall_in, .ramp_reversal, .motor_stopped,
      .hold_mode, .move_negative, .actual_position, .target_position, .actual_velocity,
      .max_velocity, .stop_on_stall_enable, .irq);

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // hold each channel until its own ready, bready until bvalid
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr

   task automatic st(input logic [31:0] exp);
      axr(RSR_STATUS_ADDR);
      chk("status", exp, rd);
   endtask : st

   task automatic wirq(input logic exp);
      int n;
      n = 0;
      while (irq !== exp && n < 10) begin
         @(posedge aclk);
         n++;
      end
      chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask : wirq

   task automatic pulse_rev();
      ramp_reversal <= 1'b1;
      @(posedge aclk);
      ramp_reversal <= 1'b0;
   endtask : pulse_rev

   task automatic t_reset();
      st(32'h0000c000);
      virt_stop_l_cond <= 1'b0;
      st(32'h00008000);
      virt_stop_r_cond <= 1'b0;
      virt_stop_l_cond <= 1'b1;
      st(32'h00004000);
      virt_stop_l_cond <= 1'b0;
      $display("done reset");
   endtask : t_reset

   task automatic t_levels();
      stall_in <= 1'b1;
      actual_velocity <= 32'h0;
      max_velocity <= 32'h0;
      target_position <= 32'h0;
      st(32'h00002780);
      actual_velocity <= 32'h5;
      max_velocity <= 32'h5;
      stall_in <= 1'b0;
      st(32'h00000380);
      // lane 0 strobe off: the clear must not reach bit 7
      axw(RSR_STATUS_ADDR, 32'h0000ffff, 4'he);
      st(32'h00000380);
      axw(RSR_STATUS_ADDR, 32'h0, 4'hf);
      st(32'h00000380);
      axw(RSR_STATUS_ADDR, 32'hffffffff, 4'hf);
      chk("bresp", {30'h0, RSR_RESP_OKAY}, {30'h0, rsp});
      st(32'h00000300);
      target_position <= 32'h1;
      max_velocity <= 32'h9;
      st(32'h0);
      $display("done levels");
   endtask : t_levels

   task automatic t_events();
      pulse_rev();
      st(32'h00001000);
      axw(RSR_STATUS_ADDR, 32'h00001000, 4'h2);
      st(32'h0);
      axw(RSR_WAIT_ADDR, 32'h00000003, 4'hf);
      motor_stopped <= 1'b1;
      @(posedge aclk);
      motor_stopped <= 1'b0;
      st(32'h00000800);
      repeat (30) @(posedge aclk);
      st(32'h0);
      $display("done events");
   endtask : t_events

   task automatic t_switch();
      axw(RSR_SWMODE_ADDR, 32'h00000020, 4'hf);
      ref_l_pin <= 1'b1;
      st(32'h00000005);
      axw(RSR_SWMODE_ADDR, 32'h00000004, 4'hf);
      st(32'h00000004);
      axw(RSR_STATUS_ADDR, 32'h00000004, 4'hf);
      axw(RSR_SWMODE_ADDR, 32'h00000012, 4'hf);
      st(32'h00000022);
      hold_mode <= 1'b1;
      st(32'h00000002);
      hold_mode <= 1'b0;
      move_negative <= 1'b1;
      st(32'h00000002);
      virt_stop_l_cond <= 1'b1;
      axw(RSR_SWMODE_ADDR, 32'h00001000, 4'hf);
      st(32'h00004011);
      virt_stop_l_cond <= 1'b0;
      move_negative <= 1'b0;
      ref_l_pin <= 1'b0;
      axw(RSR_SWMODE_ADDR, 32'h00000400, 4'hf);
      repeat (2) @(posedge aclk);
      chk("stall_stop", 32'h1, {31'h0, stop_on_stall_enable});
      stall_in <= 1'b1;
      @(posedge aclk);
      stall_in <= 1'b0;
      st(32'h00000040);
      axw(RSR_STATUS_ADDR, 32'h00000040, 4'hf);
      st(32'h0);
      $display("done switch");
   endtask : t_switch

   task automatic t_irq();
      axr(RSR_INT_STAT_ADDR);
      axr(RSR_INT_STAT_ADDR);
      chk("int_status", 32'h0, rd);
      axw(RSR_INT_MASK_ADDR, 32'h00000080, 4'hf);
      target_position <= 32'h0;
      wirq(1'b1);
      axr(RSR_INT_STAT_ADDR);
      chk("int_status", 32'h00000080, rd);
      wirq(1'b0);
      axw(RSR_INT_MASK_ADDR, 32'h00001000, 4'hf);
      axw(RSR_STATUS_ADDR, 32'h00000080, 4'hf);
      target_position <= 32'h1;
      @(posedge aclk);
      target_position <= 32'h0;
      repeat (10) @(posedge aclk);
      chk("irq", 32'h0, {31'h0, irq});
      axr(RSR_INT_STAT_ADDR);
      chk("int_status", 32'h00000080, rd);
      pulse_rev();
      wirq(1'b1);
      axr(RSR_INT_STAT_ADDR);
      wirq(1'b0);
      axr(8'hf0);
      chk("rresp", {30'h0, RSR_RESP_SLVERR}, {30'h0, rsp});
      chk("rdata", 32'h0, rd);
      axw(8'hf0, 32'hffffffff, 4'hf);
      chk("bresp", {30'h0, RSR_RESP_SLVERR}, {30'h0, rsp});
      $display("done irq");
   endtask : t_irq

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      {ref_l_pin, ref_r_pin, stall_in, ramp_reversal, motor_stopped} = 5'h00;
      {hold_mode, move_negative} = 2'h0;
      {virt_stop_l_cond, virt_stop_r_cond} = 2'h3;
      actual_position = 32'h0;
      target_position = 32'h1;
      actual_velocity = 32'h1;
      max_velocity = 32'h5;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_levels();
      t_events();
      t_switch();
      t_irq();
      complete_run();
   end
endmodule : test_ramp_status_register
